// File: verilog/dtec_map.svh
// Overview of operation
// - timer function adds one per machine cycle of six clocks
// - counter function adds one per falling edge on own count pin
// - count pin sampled once per machine cycle; high then low is an edge
// - incremented count appears in the machine cycle after detection
// - edge recognition spans two machine cycles, twelve clocks
// - counter-select bit picks internal ticks when clear, pin when set
// - mode field: timer one bits 5:4, timer zero bits 1:0
// - gate set: count only while gate pin high and run bit set
// - modes 0 to 2 equal for both timers; mode 3 differs
// - optional toggle of the count pin on each timer overflow
// - mode 00 is 13 bits: high byte plus low five bits
// - mode 10 reloads low byte from high byte and sets flag
// - timer zero mode 3: low byte own controls, high byte uses timer one
// - timer one mode 3 stops it like a cleared run bit
`ifndef DTEC_MAP_SVH
`define DTEC_MAP_SVH
`define DTEC_OFS_CTRL 8'h88
`define DTEC_OFS_MODE 8'h89
`define DTEC_OFS_TL0 8'h8A
`define DTEC_OFS_TL1 8'h8B
`define DTEC_OFS_TH0 8'h8C
`define DTEC_OFS_TH1 8'h8D
`define DTEC_OFS_STAT 8'h8E
`define DTEC_OFS_MASK 8'h8F
`define DTEC_RST_BYTE 8'h00
`define DTEC_CTRL_RUN0 4
`define DTEC_CTRL_RUN1 6
`define DTEC_CTRL_TGL0 0
`define DTEC_CTRL_TGL1 1
`define DTEC_STAT_OVF0 0
`define DTEC_STAT_OVF1 1
`define DTEC_MC_CLKS 6
`endif

// File: verilog/dtec_pkg.sv
package dtec_pkg;
   typedef enum logic [1:0] {
      DTEC_M13 = 2'b00,
      DTEC_M16 = 2'b01,
      DTEC_M8R = 2'b10,
      DTEC_MSPLIT = 2'b11
   } dtec_mode_t;
   // one half of the mode control byte
   typedef struct packed {
      logic gate;
      logic ext;
      dtec_mode_t mode;
   } dtec_tcfg_t;
endpackage : dtec_pkg

// File: verilog/dtec_top.sv
// Our own choice: the plain strobed port.
`include "dtec_map.svh"
module dtec_top
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic irq,
   input wire logic count_pin_zero_in,
   output logic count_pin_zero_out,
   output logic count_pin_zero_oe,
   input wire logic count_pin_one_in,
   output logic count_pin_one_out,
   output logic count_pin_one_oe,
   input wire logic gate_pin_zero,
   input wire logic gate_pin_one
);
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [2:0] pre_reg;
   logic tick;
   logic [1:0] cp_s1_reg, cp_s2_reg, gp_s1_reg, gp_s2_reg;
   logic [1:0] samp_reg, pend_reg, ext_evt;
   logic [7:0] mode_reg, ctrl_reg, stat_reg, mask_reg, rdata_reg;
   logic [7:0] tl0_reg, th0_reg, tl1_reg, th1_reg;
   logic [7:0] tl0_next, th0_next, tl1_next, th1_next, stat_next, rdata_next, mask_next;
   logic irq_reg;
   logic [1:0] pin_out_reg, pin_oe_reg;
   dtec_pkg::dtec_tcfg_t cfg0, cfg1;
   logic split0, run0, run1, inc0, inc1, inc_h0;
   logic [16:0] step0, step1;
   logic ovf0, ovf1, ovf_h0, set_f1;
   logic w_ctrl, w_mode, w_tl0, w_tl1, w_th0, w_th1, w_mask, r_stat;

   // reset release through two flops, assert stays asynchronous
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   assign rst_n = rst_sync_reg[1];

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         pre_reg <= 3'h0;
      else
         pre_reg <= tick ? 3'h0 : pre_reg + 3'h1;
   assign tick = (pre_reg == 3'(`DTEC_MC_CLKS - 1));

   // pins come from outside: two flops before any use
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         cp_s1_reg <= 2'h0;
         cp_s2_reg <= 2'h0;
         gp_s1_reg <= 2'h0;
         gp_s2_reg <= 2'h0;
      end
      else
      begin
         cp_s1_reg <= {count_pin_one_in, count_pin_zero_in};
         cp_s2_reg <= cp_s1_reg;
         gp_s1_reg <= {gate_pin_one, gate_pin_zero};
         gp_s2_reg <= gp_s1_reg;
      end

   // one sample per machine cycle, edge held for one more cycle
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_edge
         always_ff @(posedge clk or negedge rst_n)
            if (!rst_n)
            begin
               samp_reg[gi] <= 1'b0;
               pend_reg[gi] <= 1'b0;
            end
            else if (tick)
            begin
               samp_reg[gi] <= cp_s2_reg[gi];
               pend_reg[gi] <= samp_reg[gi] & ~cp_s2_reg[gi];
            end
         // count lands on the tick after detection
         assign ext_evt[gi] = tick & pend_reg[gi];
      end
   endgenerate

   // register decode
   assign w_ctrl = wr && (addr == `DTEC_OFS_CTRL);
   assign w_mode = wr && (addr == `DTEC_OFS_MODE);
   assign w_tl0 = wr && (addr == `DTEC_OFS_TL0);
   assign w_tl1 = wr && (addr == `DTEC_OFS_TL1);
   assign w_th0 = wr && (addr == `DTEC_OFS_TH0);
   assign w_th1 = wr && (addr == `DTEC_OFS_TH1);
   assign w_mask = wr && (addr == `DTEC_OFS_MASK);
   assign r_stat = rd && (addr == `DTEC_OFS_STAT);

   assign cfg1 = dtec_pkg::dtec_tcfg_t'(mode_reg[7:4]);
   assign cfg0 = dtec_pkg::dtec_tcfg_t'(mode_reg[3:0]);
   assign split0 = (cfg0.mode == dtec_pkg::DTEC_MSPLIT);

   // run bit, optionally qualified by the gate pin
   assign run0 = ctrl_reg[`DTEC_CTRL_RUN0] & (~cfg0.gate | gp_s2_reg[0]);
   // timer one in mode 3 acts as stopped
   assign run1 = ctrl_reg[`DTEC_CTRL_RUN1] & (~cfg1.gate | gp_s2_reg[1])
      & (cfg1.mode != dtec_pkg::DTEC_MSPLIT);
   // source select: internal tick or pin edge
   // pin edges feed the counter function
   assign inc0 = run0 & (cfg0.ext ? ext_evt[0] : tick);
   assign inc1 = run1 & (cfg1.ext ? ext_evt[1] : tick);
   // split high byte counts ticks on timer one's run bit
   assign inc_h0 = split0 & ctrl_reg[`DTEC_CTRL_RUN1] & tick;

   // one count step of either timer; bit 16 flags the rollover
   function automatic logic [16:0] dtec_step(input logic [1:0] m, input logic [7:0] tl,
      input logic [7:0] th, input logic inc);
      logic [16:0] r;
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      r = {1'b0, th, tl};
      c13 = {1'b0, th, tl[4:0]} + 14'h0001;
      c16 = {1'b0, th, tl} + 17'h00001;
      c8 = {1'b0, tl} + 9'h001;
      // shared mode behaviour, split only differs outside
      if (inc)
         unique case (dtec_pkg::dtec_mode_t'(m))
            // 13 bits, top three bits of the low byte left alone
            dtec_pkg::DTEC_M13: r = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
            dtec_pkg::DTEC_M16: r = c16;
            dtec_pkg::DTEC_M8R: r = c8[8] ? {1'b1, th, th} : {1'b0, th, c8[7:0]};
            dtec_pkg::DTEC_MSPLIT: r = {c8[8], th, c8[7:0]};
         endcase
      return r;
   endfunction : dtec_step

   // next count values; a software write beats the count step
   assign step0 = dtec_step(cfg0.mode, tl0_reg, th0_reg, inc0);
   assign step1 = dtec_step(cfg1.mode, tl1_reg, th1_reg, inc1);
   assign ovf0 = step0[16];
   assign ovf1 = step1[16];
   assign ovf_h0 = inc_h0 && (th0_reg == 8'hFF);
   assign tl0_next = w_tl0 ? wdata : step0[7:0];
   assign th0_next = w_th0 ? wdata : (split0 ? th0_reg + {7'h00, inc_h0} : step0[15:8]);
   assign tl1_next = w_tl1 ? wdata : step1[7:0];
   assign th1_next = w_th1 ? wdata : step1[15:8];
   // in split mode the high byte owns timer one's flag
   assign set_f1 = split0 ? ovf_h0 : ovf1;

   // status: read clears, a new event in the same cycle wins
   assign stat_next = ({8{~r_stat}} & stat_reg)
      | {6'h00, set_f1, ovf0};
   // next mask, so that irq never lags a mask write by a cycle
   assign mask_next = w_mask ? wdata : mask_reg;

   // read mux, unmapped addresses read zero
   assign rdata_next =
      (addr == `DTEC_OFS_CTRL) ? ctrl_reg :
      (addr == `DTEC_OFS_MODE) ? mode_reg :
      (addr == `DTEC_OFS_TL0) ? tl0_reg :
      (addr == `DTEC_OFS_TL1) ? tl1_reg :
      (addr == `DTEC_OFS_TH0) ? th0_reg :
      (addr == `DTEC_OFS_TH1) ? th1_reg :
      (addr == `DTEC_OFS_STAT) ? stat_reg :
      (addr == `DTEC_OFS_MASK) ? mask_reg : 8'h00;

   // count registers update on the counting tick itself
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         tl0_reg <= `DTEC_RST_BYTE;
         th0_reg <= `DTEC_RST_BYTE;
         tl1_reg <= `DTEC_RST_BYTE;
         th1_reg <= `DTEC_RST_BYTE;
      end
      else
      begin
         tl0_reg <= tl0_next;
         th0_reg <= th0_next;
         tl1_reg <= tl1_next;
         th1_reg <= th1_next;
      end

   // software registers, status and interrupt
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         mode_reg <= `DTEC_RST_BYTE;
         ctrl_reg <= `DTEC_RST_BYTE;
         mask_reg <= `DTEC_RST_BYTE;
         stat_reg <= `DTEC_RST_BYTE;
         rdata_reg <= `DTEC_RST_BYTE;
         irq_reg <= 1'b0;
      end
      else
      begin
         if (w_mode)
            mode_reg <= wdata;
         if (w_ctrl)
            ctrl_reg <= wdata;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         rdata_reg <= rd ? rdata_next : 8'h00; // data stands one cycle only
         irq_reg <= |(stat_next & mask_next); // no extra delay past flag or mask
      end

   // toggle outputs start high; pin is only driven while enabled
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_tgl
         logic hit;
         assign hit = (gi == 0) ? ovf0 : ovf1;
         always_ff @(posedge clk or negedge rst_n)
            if (!rst_n)
            begin
               pin_out_reg[gi] <= 1'b1;
               pin_oe_reg[gi] <= 1'b0;
            end
            else
            begin
               pin_oe_reg[gi] <= ctrl_reg[`DTEC_CTRL_TGL0 + gi];
               if (!ctrl_reg[`DTEC_CTRL_TGL0 + gi])
                  pin_out_reg[gi] <= 1'b1;
               else if (hit)
                  pin_out_reg[gi] <= ~pin_out_reg[gi];
            end
      end
   endgenerate

   assign rdata = rdata_reg;
   assign irq = irq_reg;
   assign count_pin_zero_out = pin_out_reg[0];
   assign count_pin_zero_oe = pin_oe_reg[0];
   assign count_pin_one_out = pin_out_reg[1];
   assign count_pin_one_oe = pin_oe_reg[1];

   // checks on the counting core
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_tick_period: assert property (tick |=> !tick [*5] ##1 tick)
      else $error("machine cycle is not six clocks");
   a_edge_sample: assert property (tick && samp_reg[0] && !cp_s2_reg[0] |=> pend_reg[0])
      else $error("falling sample pair not registered");
   a_edge_visible: assert property (ext_evt[0] && inc0 && cfg0.mode == dtec_pkg::DTEC_M16
      && !w_tl0 && !w_th0 |=> {th0_reg, tl0_reg} == $past({th0_reg, tl0_reg}) + 16'h0001)
      else $error("pin edge not counted in next cycle");
   a_gate_hold: assert property (cfg0.gate && !gp_s2_reg[0] && !w_tl0 |=> $stable(tl0_reg))
      else $error("gated timer counted while gate low");
   a_reload: assert property (cfg0.mode == dtec_pkg::DTEC_M8R && inc0 && tl0_reg == 8'hFF
      && !w_tl0 && !w_th0 |=> tl0_reg == $past(th0_reg) && stat_reg[0])
      else $error("auto reload or flag missing");
   a_t1_stop: assert property (cfg1.mode == dtec_pkg::DTEC_MSPLIT && !w_tl1 && !w_th1
      |=> $stable({th1_reg, tl1_reg}))
      else $error("timer one counted in mode 3");
   a_split_high: assert property (inc_h0 && th0_reg == 8'hFF |=> stat_reg[1])
      else $error("split high byte did not set timer one flag");
   a_ovf_flag: assert property (ovf0 |=> stat_reg[0] ##1 (stat_reg[0] || $past(r_stat)))
      else $error("overflow flag not held");
   a_toggle_pin: assert property (ovf0 && ctrl_reg[0] && pin_oe_reg[0]
      |=> count_pin_zero_out != $past(count_pin_zero_out))
      else $error("toggle output missed overflow");
   a_irq_level: assert property (irq == ((stat_reg & mask_reg) != 8'h00))
      else $error("interrupt level differs from unmasked flags");
endmodule : dtec_top

// File: tb/dtec_pin_model.sv
module dtec_pin_model
(
   input wire logic clk,
   output logic pin_zero,
   output logic pin_one,
   output logic gate_zero,
   output logic gate_one
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle count pins rest high, as the port pull-ups would leave them
   initial
   begin
      pin_zero = 1'b1;
      pin_one = 1'b1;
      gate_zero = 1'b0;
      gate_one = 1'b0;
   end
   // gate level moves just after an edge
   task automatic set_gate(input int t, input logic v);
      @(posedge clk);
      if (t == 0)
         gate_zero <= v;
      else
         gate_one <= v;
   endtask : set_gate
   // each level held two machine cycles
   task automatic falls(input int t, input int n);
      repeat (2 * n)
      begin
         @(posedge clk);
         if (t == 0)
            pin_zero <= ~pin_zero;
         else
            pin_one <= ~pin_one;
         repeat (11) @(posedge clk);
      end
   endtask : falls
endmodule : dtec_pin_model

// File: tb/tb_dtec_top.sv
`include "dtec_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_dtec_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata, rv;
   logic irq, out0, oe0, out1, oe1, m0, m1, g0, g1;
   int fails = 0;
   int compares = 0;
   // pin level: the block's toggle driver wins while enabled
   wire cp0 = oe0 ? out0 : m0;
   wire cp1 = oe1 ? out1 : m1;
   // 50 MHz clock
   always #10 clk = ~clk;
   dtec_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .count_pin_zero_in(cp0),
      .count_pin_zero_out(out0), .count_pin_zero_oe(oe0), .count_pin_one_in(cp1),
      .count_pin_one_out(out1), .count_pin_one_oe(oe1), .gate_pin_zero(g0),
      .gate_pin_one(g1));
   dtec_pin_model pm_u (.clk(clk), .pin_zero(m0), .pin_one(m1), .gate_zero(g0),
      .gate_one(g1));
   // bus cycles, one strobe cycle each
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : rd_reg
   // run bits set for exactly k clock cycles (k >= 2)
   task automatic run_for(input logic [7:0] on, input logic [7:0] off, input int k);
      wr_reg(`DTEC_OFS_CTRL, on);
      repeat (k - 2) @(posedge clk);
      wr_reg(`DTEC_OFS_CTRL, off);
      repeat (2) @(posedge clk);
      #1;
   endtask : run_for
   // expected {flag, high, low} after n steps in modes 0 to 2
   function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] h,
      input logic [7:0] l, input int n);
      logic o;
      o = 1'b0;
      repeat (n)
      begin
         if (m == 2'b10)
         begin
            o |= (l == 8'hFF);
            l = (l == 8'hFF) ? h : l + 8'h01;
         end
         else if (m == 2'b01)
         begin
            o |= ({h, l} == 16'hFFFF);
            {h, l} = {h, l} + 16'h0001;
         end
         else
         begin
            o |= ({h, l[4:0]} == 13'h1FFF);
            {h, l[4:0]} = {h, l[4:0]} + 13'h0001;
         end
      end
      return {o, h, l};
   endfunction : step
   // one timer in one of modes 0 to 2 from a start near rollover
   task automatic timer_case(input int t, input logic [1:0] m);
      logic [7:0] h, l;
      logic [16:0] e;
      int n;
      h = ($urandom & 1) ? 8'hFF : 8'($urandom);
      l = 8'hF8 | 8'($urandom);
      n = $urandom_range(8, 1);
      e = step(m, h, l, n);
      wr_reg(`DTEC_OFS_MODE, 8'(m) << (4 * t));
      wr_reg(`DTEC_OFS_TL0 + 8'(t), l);
      wr_reg(`DTEC_OFS_TH0 + 8'(t), h);
      rd_reg(`DTEC_OFS_STAT);
      run_for(8'h10 << (2 * t), 8'h00, 6 * n);
      `CHK(irq, e[16])
      rd_reg(`DTEC_OFS_TL0 + 8'(t));
      `CHK(rv, e[7:0])
      rd_reg(`DTEC_OFS_TH0 + 8'(t));
      `CHK(rv, e[15:8])
      rd_reg(`DTEC_OFS_STAT);
      `CHK(rv[t], e[16])
   endtask : timer_case
   task automatic tally_and_finish;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   // watchdog, far beyond the few thousand cycles the tests need
   initial
   begin
      #400000;
      fails++;
      tally_and_finish();
   end
   // main sequence
   initial
   begin
      int n;
      logic [7:0] r;
      void'($urandom(39));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_reg(`DTEC_OFS_MODE);
      `CHK(rv, 8'h00)
      r = 8'($urandom);
      wr_reg(`DTEC_OFS_MODE, r);
      rd_reg(`DTEC_OFS_MODE);
      `CHK(rv, r)
      rd_reg(8'h80);
      `CHK(rv, 8'h00)
      $display("done registers");
      wr_reg(`DTEC_OFS_MASK, 8'h03);
      for (int t = 0; t < 2; t++)
         for (int m = 0; m < 3; m++)
            repeat (3) timer_case(t, 2'(m));
      $display("done modes");
      wr_reg(`DTEC_OFS_MODE, 8'h33);
      wr_reg(`DTEC_OFS_TL0, 8'h55);
      wr_reg(`DTEC_OFS_TH0, 8'hFF);
      wr_reg(`DTEC_OFS_TL1, 8'h77);
      wr_reg(`DTEC_OFS_MASK, 8'h00);
      run_for(8'h40, 8'h00, 12);
      `CHK(irq, 1'b0)
      rd_reg(`DTEC_OFS_TH0);
      `CHK(rv, 8'h01)
      rd_reg(`DTEC_OFS_TL0);
      `CHK(rv, 8'h55)
      rd_reg(`DTEC_OFS_TL1);
      `CHK(rv, 8'h77)
      wr_reg(`DTEC_OFS_MASK, 8'h02);
      rd_reg(`DTEC_OFS_MASK);
      `CHK(irq, 1'b1)
      rd_reg(`DTEC_OFS_STAT);
      `CHK(rv, 8'h02)
      rd_reg(`DTEC_OFS_MASK);
      `CHK(irq, 1'b0)
      $display("done split");
      for (int t = 0; t < 2; t++)
      begin
         wr_reg(`DTEC_OFS_MODE, 8'h09 << (4 * t));
         wr_reg(`DTEC_OFS_TL0 + 8'(t), 8'h00);
         wr_reg(`DTEC_OFS_TH0 + 8'(t), 8'h00);
         run_for(8'h10 << (2 * t), 8'h00, 60);
         rd_reg(`DTEC_OFS_TL0 + 8'(t));
         `CHK(rv, 8'h00)
         pm_u.set_gate(t, 1'b1);
         repeat (3) @(posedge clk);
         run_for(8'h10 << (2 * t), 8'h00, 60);
         rd_reg(`DTEC_OFS_TL0 + 8'(t));
         `CHK(rv, 8'h0A)
         pm_u.set_gate(t, 1'b0);
      end
      $display("done gate");
      for (int t = 0; t < 2; t++)
      begin
         n = $urandom_range(8, 1);
         wr_reg(`DTEC_OFS_MODE, 8'h05 << (4 * t));
         wr_reg(`DTEC_OFS_TL0 + 8'(t), 8'h00);
         wr_reg(`DTEC_OFS_CTRL, 8'h10 << (2 * t));
         pm_u.falls(t, n);
         repeat (30) @(posedge clk);
         wr_reg(`DTEC_OFS_CTRL, 8'h00);
         rd_reg(`DTEC_OFS_TL0 + 8'(t));
         `CHK(rv, 8'(n))
      end
      $display("done counter");
      wr_reg(`DTEC_OFS_CTRL, 8'h03);
      rd_reg(`DTEC_OFS_MODE);
      `CHK({oe0, out0}, 2'b11)
      `CHK({oe1, out1}, 2'b11)
      wr_reg(`DTEC_OFS_MODE, 8'h22);
      wr_reg(`DTEC_OFS_TH0, 8'h80);
      wr_reg(`DTEC_OFS_TL0, 8'hFF);
      wr_reg(`DTEC_OFS_TH1, 8'h40);
      wr_reg(`DTEC_OFS_TL1, 8'hFF);
      run_for(8'h53, 8'h03, 6);
      `CHK(out0, 1'b0)
      `CHK(out1, 1'b0)
      rd_reg(`DTEC_OFS_TL0);
      `CHK(rv, 8'h80)
      rd_reg(`DTEC_OFS_TL1);
      `CHK(rv, 8'h40)
      wr_reg(`DTEC_OFS_CTRL, 8'h00);
      $display("done toggle");
      tally_and_finish();
   end
endmodule : tb_dtec_top
